// File: verification/mitf_exec_tb.sv
// Self-checking bench for the instruction execution timer
module mitf_exec_tb
    import mitf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and instance
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    mitf_req_s req = '0;
    logic req_ready;
    logic done;
    mitf_res_s res;
    int fails = 0;
    int compares = 0;
    int cyc = 0;

    mitf_exec DUT (
        .sys_clk(sys_clk),
        .reset(reset),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .done(done),
        .res(res)
    );

    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            fails++;
            close_out();
        end
    end
    // ----------------------------------------
    // Checks and helpers
    // ----------------------------------------
    task automatic close_out();
        $display("Counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte

    task automatic chk_flag(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_flag

    function automatic mitf_req_s mk(mitf_class_e c, logic [2:0] s, logic [2:0] bs,
        logic [7:0] a, logic [7:0] sr, logic [7:0] bb, logic cy, logic [7:0] p, logic [7:0] l);
        mk = '{cls: c, sub: s, bit_sel: bs, acc: a, src: sr, b: bb, carry: cy, pin: p, latch: l};
    endfunction : mk

    // Issue one instruction and count edges until done
    task automatic run(input mitf_req_s r, output logic [7:0] n);
        req_valid <= 1'b1;
        req <= r;
        @(posedge sys_clk);
        while (req_ready !== 1'b1)
            @(posedge sys_clk);
        req_valid <= 1'b0;
        @(posedge sys_clk);
        n = 8'h01;
        while (done !== 1'b1 && n < 8'h14)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask : run

    task automatic time_one(input mitf_class_e c, input logic [7:0] ln, input logic [7:0] cy);
        logic [7:0] n;
        run(mk(c, 3'h0, 3'h0, 8'h00, 8'h02, 8'h00, 1'b0, 8'h00, 8'h00), n);
        chk_byte("edges", cy, n);
        chk_byte("cycles", cy, {4'h0, res.cycles});
        chk_byte("length", ln, {6'h00, res.length});
    endtask : time_one
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_handshake();
        chk_flag("ready idle", 1'b1, req_ready);
        chk_flag("done idle", 1'b0, done);
        req_valid <= 1'b1;
        req <= mk(MITF_MOV_THREE, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00);
        @(posedge sys_clk);
        req <= mk(MITF_MOV_ACC_REG, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00);
        repeat (2)
        begin
            @(posedge sys_clk);
            chk_flag("ready busy", 1'b0, req_ready);
            chk_flag("done early", 1'b0, done);
        end
        @(posedge sys_clk);
        chk_flag("done third", 1'b1, done);
        chk_byte("length", 8'h03, {6'h00, res.length});
        req_valid <= 1'b0;
        @(posedge sys_clk);
        chk_flag("done next", 1'b1, done);
        chk_byte("cycles", 8'h01, {4'h0, res.cycles});
        $display("Test handshake finished");
    endtask : t_handshake

    task automatic t_timing();
        time_one(MITF_EXTENDED_MEMORY_MOVE, 8'h01, 8'h04);
        time_one(MITF_CODE_TABLE_READ, 8'h01, 8'h04);
        time_one(MITF_MOV_ACC_REG, 8'h01, 8'h01);
        time_one(MITF_MOV_ACC_IND, 8'h01, 8'h02);
        time_one(MITF_MOV_THREE, 8'h03, 8'h03);
        time_one(MITF_CARRY_BIT, 8'h01, 8'h01);
        time_one(MITF_DIRECT_BIT, 8'h02, 8'h02);
        time_one(MITF_REL_SHORT, 8'h02, 8'h03);
        time_one(MITF_LONG_JUMP_CALL, 8'h03, 8'h04);
        time_one(MITF_PAGE_JUMP_CALL, 8'h02, 8'h03);
        time_one(MITF_REL_LONG, 8'h03, 8'h04);
        time_one(MITF_DECREMENT_BRANCH_NONZERO, 8'h02, 8'h03);
        time_one(MITF_JUMP_INDIRECT, 8'h01, 8'h03);
        time_one(MITF_NIBBLE_EXCHANGE, 8'h01, 8'h02);
        $display("Test timing finished");
    endtask : t_timing

    task automatic t_arith();
        logic [7:0] a [4];
        logic [7:0] s [4];
        logic [8:0] w;
        logic [7:0] t7;
        logic [4:0] t4;
        logic [7:0] n;
        logic cin;
        mitf_class_e c;
        a = '{8'h7f, 8'h80, 8'hff, 8'h00};
        s = '{8'h01, 8'h01, 8'h01, 8'h00};
        for (int k = 0; k < 16; k++)
        begin
            cin = k[0];
            c = mitf_class_e'(k[1] ? MITF_SUBTRACT_WITH_BORROW :
                (k[0] ? MITF_ADD_WITH_CARRY_IN : MITF_ADD));
            if (k[1] == 1'b0)
            begin
                w = {1'b0, a[k / 4]} + {1'b0, s[k / 4]} + 9'(cin);
                t7 = {1'b0, a[k / 4][6:0]} + {1'b0, s[k / 4][6:0]} + 8'(cin);
                t4 = {1'b0, a[k / 4][3:0]} + {1'b0, s[k / 4][3:0]} + 5'(cin);
            end
            else
            begin
                w = {1'b0, a[k / 4]} - {1'b0, s[k / 4]} - 9'(cin);
                t7 = {1'b0, a[k / 4][6:0]} - {1'b0, s[k / 4][6:0]} - 8'(cin);
                t4 = {1'b0, a[k / 4][3:0]} - {1'b0, s[k / 4][3:0]} - 5'(cin);
            end
            run(mk(c, 3'h0, 3'h0, a[k / 4], s[k / 4], 8'h00, cin | ~k[1], 8'h00, 8'h00), n);
            chk_byte("acc", w[7:0], res.acc);
            chk_flag("carry", w[8], res.carry);
            chk_flag("overflow", t7[7] ^ w[8], res.signed_overflow_flag);
            chk_flag("half carry", t4[4], res.half_carry_flag);
        end
        $display("Test arithmetic finished");
    endtask : t_arith

    task automatic t_mul();
        logic [7:0] a [3];
        logic [7:0] b [3];
        logic [15:0] p;
        logic [7:0] n;
        a = '{8'h10, 8'h0f, 8'hff};
        b = '{8'h10, 8'h11, 8'hff};
        for (int i = 0; i < 3; i++)
        begin
            p = {8'h00, a[i]} * {8'h00, b[i]};
            run(mk(MITF_MUL, 3'h0, 3'h0, a[i], 8'h00, b[i], 1'b1, 8'h00, 8'h00), n);
            chk_byte("mul edges", 8'h09, n);
            chk_byte("product low", p[7:0], res.acc);
            chk_byte("product high", p[15:8], res.b);
            chk_flag("carry", 1'b0, res.carry);
            chk_flag("overflow", p > 16'h00ff, res.signed_overflow_flag);
        end
        $display("Test multiply finished");
    endtask : t_mul

    task automatic t_nibble_branch();
        logic [7:0] d [3];
        logic [7:0] n;
        run(mk(MITF_NIBBLE_EXCHANGE, 3'h0, 3'h0, 8'ha5, 8'h3c, 8'h00, 1'b0, 8'h00, 8'h00), n);
        chk_byte("nibble acc", 8'hac, res.acc);
        chk_byte("nibble mem", 8'h35, res.mem);
        d = '{8'h01, 8'h02, 8'h00};
        for (int i = 0; i < 3; i++)
        begin
            run(mk(MITF_DECREMENT_BRANCH_NONZERO, 3'h0, 3'h0, 8'h00, d[i], 8'h00, 1'b0,
                   8'h00, 8'h00), n);
            chk_flag("taken", d[i] != 8'h01, res.taken);
            chk_byte("decremented", d[i] - 8'h01, res.mem);
        end
        $display("Test nibble and branch finished");
    endtask : t_nibble_branch

    task automatic t_port();
        logic [2:0] sb [9];
        logic [2:0] bs [9];
        logic [7:0] ex [9];
        logic [7:0] n;
        run(mk(MITF_PORT_READ, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 8'h3c, 8'hc3), n);
        chk_byte("pin read", 8'h3c, res.acc);
        sb = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h1, 3'h2};
        bs = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h3, 3'h0, 3'h7};
        ex = '{8'h18, 8'h7e, 8'h66, 8'h5b, 8'h59, 8'h58, 8'h52, 8'h5b, 8'hda};
        for (int k = 0; k < 9; k++)
        begin
            run(mk(mitf_class_e'(k < 6 ? MITF_PORT_RMW : MITF_PORT_BIT), sb[k], bs[k], 8'h3c,
                   8'h00, 8'h00, 1'b1, 8'ha5, 8'h5a), n);
            chk_byte("port data", ex[k], res.port_data);
            chk_flag("port write", 1'b1, res.port_wr);
        end
        $display("Test port finished");
    endtask : t_port
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_handshake();
        t_timing();
        t_arith();
        t_mul();
        t_nibble_branch();
        t_port();
        close_out();
    end
endmodule : mitf_exec_tb

// File: verilog/mitf_defines.svh
// Instruction length and timing constants for the execution timer
`ifndef MITF_DEFINES_SVH
`define MITF_DEFINES_SVH
// ----------------------------------------
// Instruction byte lengths
// ----------------------------------------
`define MITF_LEN_1 2'h1
`define MITF_LEN_2 2'h2
`define MITF_LEN_3 2'h3
// ----------------------------------------
// Instruction cycle counts
// ----------------------------------------
`define MITF_CYC_1 4'h1
`define MITF_CYC_2 4'h2
`define MITF_CYC_3 4'h3
`define MITF_CYC_4 4'h4
`define MITF_CYC_9 4'h9
`endif

// File: verilog/mitf_exec.sv
// Instruction timing, port read-modify-write and arithmetic flag unit
// Contract
// - Extended memory moves: 1 byte, 4 cycles
// - Code table reads: 1 byte, 4 cycles
// - Acc-register move 1 cycle, indirect 2
// - Three-byte moves complete in 3 cycles
// - Carry bit ops 1/1, direct bit 2/2
// - Two-byte relative branches take 3 cycles
// - Long jump and call: 3 bytes, 4 cycles
// - Page jump and call: 2 bytes, 3 cycles
// - Three-byte conditional branches take 4 cycles
// - Register decrement branch: 2 bytes, 3 cycles
// - Indirect jump: 1 byte, 3 cycles
// - Nibble exchange swaps low nibbles, 2 cycles
// - Port input reads the pin level
// - Port modify instructions read the latch
// - Bit writes rewrite whole latch byte
// - Add carry from bit 7
// - Add overflow is carry6 xor carry7
// - Add half carry from bit 3
// - Carry-in only for add with carry
// - Subtract borrow flag from bit 7
// - Subtract overflow and half borrow flags
// - Multiply low byte acc, high byte B
// - Multiply clears carry, overflow above 255
`include "mitf_defines.svh"
module mitf_exec
    import mitf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Request
    input wire logic req_valid,
    input mitf_req_s req,
    output logic req_ready,
    // Result
    output logic done,
    output mitf_res_s res
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    mitf_state_s state_q;
    mitf_state_s state_d;
    logic take;
    logic cin;
    logic [8:0] sum9;
    logic [7:0] sum7;
    logic [4:0] sum4;
    logic [8:0] dif9;
    logic [7:0] dif7;
    logic [4:0] dif4;
    logic [15:0] prod;
    logic [7:0] rmw;
    logic [7:0] bit_mask;
    logic [1:0] len;
    logic [3:0] cyc;

    assign done = state_q.busy && (state_q.cnt == 4'h0);
    assign req_ready = !state_q.busy || done;
    assign take = req_valid && req_ready;
    assign res = state_q.res;

    // ----------------------------------------
    // Length and timing per class
    // ----------------------------------------
    always_comb
    begin
        len = `MITF_LEN_1;
        cyc = `MITF_CYC_1;
        case (req.cls)
            MITF_MOV_ACC_REG, MITF_CARRY_BIT, MITF_ADD, MITF_ADD_WITH_CARRY_IN,
            MITF_SUBTRACT_WITH_BORROW, MITF_NOP:
            begin
                len = `MITF_LEN_1;
                cyc = `MITF_CYC_1;
            end
            MITF_MOV_ACC_IND, MITF_NIBBLE_EXCHANGE:
            begin
                len = `MITF_LEN_1;
                cyc = `MITF_CYC_2;
            end
            MITF_MOV_THREE:
            begin
                len = `MITF_LEN_3;
                cyc = `MITF_CYC_3;
            end
            MITF_EXTENDED_MEMORY_MOVE, MITF_CODE_TABLE_READ:
            begin
                len = `MITF_LEN_1;
                cyc = `MITF_CYC_4;
            end
            MITF_DIRECT_BIT, MITF_PORT_READ, MITF_PORT_RMW, MITF_PORT_BIT:
            begin
                len = `MITF_LEN_2;
                cyc = `MITF_CYC_2;
            end
            MITF_REL_SHORT, MITF_PAGE_JUMP_CALL, MITF_DECREMENT_BRANCH_NONZERO:
            begin
                len = `MITF_LEN_2;
                cyc = `MITF_CYC_3;
            end
            MITF_LONG_JUMP_CALL, MITF_REL_LONG:
            begin
                len = `MITF_LEN_3;
                cyc = `MITF_CYC_4;
            end
            MITF_JUMP_INDIRECT:
            begin
                len = `MITF_LEN_1;
                cyc = `MITF_CYC_3;
            end
            MITF_MUL:
            begin
                len = `MITF_LEN_1;
                cyc = `MITF_CYC_9;
            end
            default:
            begin
                len = `MITF_LEN_1;
                cyc = `MITF_CYC_1;
            end
        endcase
    end

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    assign cin = (req.cls == MITF_ADD) ? 1'b0 : req.carry;
    assign sum9 = {1'b0, req.acc} + {1'b0, req.src} + {8'h00, cin};
    assign sum7 = {1'b0, req.acc[6:0]} + {1'b0, req.src[6:0]} + {7'h00, cin};
    assign sum4 = {1'b0, req.acc[3:0]} + {1'b0, req.src[3:0]} + {4'h0, cin};
    assign dif9 = {1'b0, req.acc} - {1'b0, req.src} - {8'h00, req.carry};
    assign dif7 = {1'b0, req.acc[6:0]} - {1'b0, req.src[6:0]} - {7'h00, req.carry};
    assign dif4 = {1'b0, req.acc[3:0]} - {1'b0, req.src[3:0]} - {4'h0, req.carry};
    assign prod = req.acc * req.b;
    assign bit_mask = 8'h01 << req.bit_sel;

    // Port modify uses latch, never pin
    always_comb
    begin
        case (req.sub)
            3'h0: rmw = req.latch & req.acc;
            3'h1: rmw = req.latch | req.acc;
            3'h2: rmw = req.latch ^ req.acc;
            3'h3: rmw = req.latch + 8'h01;
            3'h4: rmw = req.latch - 8'h01;
            default: rmw = req.latch ^ bit_mask;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        if (done)
        begin
            state_d.busy = 1'b0;
        end
        else if (state_q.busy)
        begin
            state_d.cnt = state_q.cnt - 4'h1;
        end
        if (take)
        begin
            state_d.busy = 1'b1;
            state_d.cnt = cyc - 4'h1;
            state_d.res = '0;
            state_d.res.length = len;
            state_d.res.cycles = cyc;
            state_d.res.acc = req.acc;
            state_d.res.b = req.b;
            state_d.res.mem = req.src;
            state_d.res.carry = req.carry;
            state_d.res.port_data = req.latch;
            case (req.cls)
                MITF_ADD, MITF_ADD_WITH_CARRY_IN:
                begin
                    state_d.res.acc = sum9[7:0];
                    state_d.res.carry = sum9[8];
                    state_d.res.signed_overflow_flag = sum7[7] ^ sum9[8];
                    state_d.res.half_carry_flag = sum4[4];
                end
                MITF_SUBTRACT_WITH_BORROW:
                begin
                    state_d.res.acc = dif9[7:0];
                    state_d.res.carry = dif9[8];
                    state_d.res.signed_overflow_flag = dif7[7] ^ dif9[8];
                    state_d.res.half_carry_flag = dif4[4];
                end
                MITF_MUL:
                begin
                    state_d.res.acc = prod[7:0];
                    state_d.res.b = prod[15:8];
                    state_d.res.carry = 1'b0;
                    state_d.res.signed_overflow_flag = |prod[15:8];
                end
                MITF_NIBBLE_EXCHANGE:
                begin
                    state_d.res.acc = {req.acc[7:4], req.src[3:0]};
                    state_d.res.mem = {req.src[7:4], req.acc[3:0]};
                end
                MITF_DECREMENT_BRANCH_NONZERO:
                begin
                    state_d.res.mem = req.src - 8'h01;
                    state_d.res.taken = (req.src != 8'h01);
                end
                MITF_PORT_READ:
                begin
                    state_d.res.acc = req.pin;
                end
                MITF_PORT_RMW:
                begin
                    state_d.res.port_wr = 1'b1;
                    state_d.res.port_data = rmw;
                end
                MITF_PORT_BIT:
                begin
                    state_d.res.port_wr = 1'b1;
                    case (req.sub)
                        3'h0: state_d.res.port_data = req.latch & ~bit_mask;
                        3'h1: state_d.res.port_data = req.latch | bit_mask;
                        default: state_d.res.port_data = req.carry ?
                            (req.latch | bit_mask) : (req.latch & ~bit_mask);
                    endcase
                end
                default:
                begin
                    state_d.res.taken = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_wait3;
        !done [*3] ##1 done;
    endsequence

    sequence s_wait1;
        !done ##1 done;
    endsequence

    sequence s_wait2;
        !done [*2] ##1 done;
    endsequence

    a_xmem_timing: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_EXTENDED_MEMORY_MOVE |=> s_wait3 ##0 res.length == 2'h1)
        else $error("extended move timing wrong");
    a_table_timing: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_CODE_TABLE_READ |=> s_wait3)
        else $error("table read timing wrong");
    a_reg_move: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_MOV_ACC_REG |=> done)
        else $error("register move not one cycle");
    a_three_move: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_MOV_THREE |=> !done [*2] ##1 done)
        else $error("three byte move timing wrong");
    a_short_branch: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_REL_SHORT |=> !done [*2] ##1 done ##0 res.length == 2'h2)
        else $error("short branch timing wrong");
    a_long_call: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_LONG_JUMP_CALL |=> s_wait3 ##0 res.length == 2'h3)
        else $error("long call timing wrong");
    a_add_carry: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_ADD |=>
        res.carry == (({1'b0, $past(req.acc)} + {1'b0, $past(req.src)}) > 9'h0ff))
        else $error("add carry wrong");
    a_mul_result: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_MUL |=> {res.b, res.acc} == $past(req.acc) * $past(req.b)
        && !res.carry && res.signed_overflow_flag == ($past(req.b) * $past(req.acc) > 255))
        else $error("multiply result wrong");
    a_bit_keep: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_PORT_BIT |=> res.port_wr &&
        ((res.port_data ^ $past(req.latch)) & ~(8'h01 << $past(req.bit_sel))) == 8'h00)
        else $error("bit write disturbed other bits");
    a_pin_read: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_PORT_READ |=> res.acc == $past(req.pin) && !res.port_wr)
        else $error("port read not from pin");
    a_carry_bit: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_CARRY_BIT |=> done ##0 res.length == 2'h1)
        else $error("carry bit op timing wrong");
    a_direct_bit: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_DIRECT_BIT |=> s_wait1 ##0 res.length == 2'h2)
        else $error("direct bit op timing wrong");
    a_page_call: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_PAGE_JUMP_CALL |=> s_wait2 ##0 res.length == 2'h2)
        else $error("page call timing wrong");
    a_cond_branch: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_REL_LONG |=> s_wait3 ##0 res.length == 2'h3)
        else $error("conditional branch timing wrong");
    a_dec_branch: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_DECREMENT_BRANCH_NONZERO |=>
        res.taken == ($past(req.src) != 8'h01) && res.mem == $past(req.src) - 8'h01)
        else $error("decrement branch wrong");
    a_jump_indirect: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_JUMP_INDIRECT |=> s_wait2 ##0 res.length == 2'h1)
        else $error("indirect jump timing wrong");
    a_nibble_swap: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_NIBBLE_EXCHANGE |=> (res.acc[7:4] == $past(req.acc[7:4])
        && res.acc[3:0] == $past(req.src[3:0]) && res.mem[3:0] == $past(req.acc[3:0]))
        ##0 s_wait1)
        else $error("nibble exchange wrong");
    a_rmw_latch: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_PORT_RMW && req.sub == 3'h0 |=>
        res.port_wr && res.port_data == ($past(req.latch) & $past(req.acc)))
        else $error("port modify not from latch");
    a_add_overflow: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_ADD |=> res.signed_overflow_flag ==
        (($past(req.acc[7]) == $past(req.src[7])) && (res.acc[7] != $past(req.acc[7]))))
        else $error("add overflow wrong");
    a_half_carry: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_ADD |=> res.half_carry_flag ==
        (({1'b0, $past(req.acc[3:0])} + {1'b0, $past(req.src[3:0])}) > 5'h0f))
        else $error("add half carry wrong");
    a_adc_carry: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_ADD_WITH_CARRY_IN |=> res.carry ==
        (({1'b0, $past(req.acc)} + {1'b0, $past(req.src)} + {8'h00, $past(req.carry)}) > 9'h0ff))
        else $error("add with carry wrong");
    a_sub_borrow: assert property (@(posedge sys_clk) disable iff (reset)
        take && req.cls == MITF_SUBTRACT_WITH_BORROW |=> res.carry ==
        ({1'b0, $past(req.acc)} < ({1'b0, $past(req.src)} + {8'h00, $past(req.carry)})))
        else $error("subtract borrow wrong");
endmodule : mitf_exec

// File: verilog/mitf_pkg.sv
// Types shared by the instruction execution timer
package mitf_pkg;
    typedef enum logic [4:0] {
        MITF_NOP = 5'h00,
        MITF_MOV_ACC_REG = 5'h01,
        MITF_MOV_ACC_IND = 5'h02,
        MITF_MOV_THREE = 5'h03,
        MITF_EXTENDED_MEMORY_MOVE = 5'h04,
        MITF_CODE_TABLE_READ = 5'h05,
        MITF_CARRY_BIT = 5'h06,
        MITF_DIRECT_BIT = 5'h07,
        MITF_REL_SHORT = 5'h08,
        MITF_LONG_JUMP_CALL = 5'h09,
        MITF_PAGE_JUMP_CALL = 5'h0a,
        MITF_REL_LONG = 5'h0b,
        MITF_DECREMENT_BRANCH_NONZERO = 5'h0c,
        MITF_JUMP_INDIRECT = 5'h0d,
        MITF_NIBBLE_EXCHANGE = 5'h0e,
        MITF_ADD = 5'h0f,
        MITF_ADD_WITH_CARRY_IN = 5'h10,
        MITF_SUBTRACT_WITH_BORROW = 5'h11,
        MITF_MUL = 5'h12,
        MITF_PORT_READ = 5'h13,
        MITF_PORT_RMW = 5'h14,
        MITF_PORT_BIT = 5'h15
    } mitf_class_e;

    // Sub-operation: RMW 0 and 1 or 2 xor 3 inc 4 dec 5 cpl; bit 0 clr 1 set 2 carry
    typedef struct packed {
        mitf_class_e cls;
        logic [2:0] sub;
        logic [2:0] bit_sel;
        logic [7:0] acc;
        logic [7:0] src;
        logic [7:0] b;
        logic carry;
        logic [7:0] pin;
        logic [7:0] latch;
    } mitf_req_s;

    typedef struct packed {
        logic [1:0] length;
        logic [3:0] cycles;
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] mem;
        logic carry;
        logic signed_overflow_flag;
        logic half_carry_flag;
        logic taken;
        logic port_wr;
        logic [7:0] port_data;
    } mitf_res_s;

    typedef struct packed {
        logic busy;
        logic [3:0] cnt;
        mitf_res_s res;
    } mitf_state_s;
endpackage : mitf_pkg
